// File: logic/cfe_top.sv
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - single-flag tests for overflow, carry, zero
// - sign tests, always true, saturation test
// - carry or zero gives not-higher / higher
// - sign xor overflow gives signed less/ge
// - adding zero gives signed le / gt
// - clamp results to signed word limits
// - zero extension fills upper bits zero
// - sign extension copies top bit of the selected byte or half
// - per-flag keep, clear, or take result
// - restore code reloads flags from saved copy
// - bit read returns selected byte bit
// - bit write changes only selected bit
// - issue count spaces different instructions
// - repeat and latency counts space issues
// - condition comes from 4-bit field
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`default_nettype none
module cfe_top (
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   // condition test
   input wire logic [3:0] i_cond,
   output logic o_cond_true,
   // flag update
   input wire logic i_upd_valid,
   input wire logic [9:0] i_upd_codes,
   input wire logic [4:0] i_result_flags,
   input wire logic [4:0] i_saved_flags,
   output logic [4:0] o_flags,
   // extension and saturation
   input wire logic [31:0] i_ext_in,
   input wire logic [1:0] i_ext_size,
   input wire logic i_ext_signed,
   output logic [31:0] o_ext_out,
   input wire logic [32:0] i_sat_in,
   output logic [31:0] o_sat_out,
   output logic o_sat_hit,
   // single-bit memory helper
   input wire logic [7:0] i_mem_byte,
   input wire logic [2:0] i_bit_num,
   input wire logic i_bit_val,
   output logic o_bit_rd,
   output logic [7:0] o_bit_wr_byte,
   // issue timing
   input wire logic i_issue,
   input wire logic i_same_insn,
   input wire logic i_dependent,
   input wire logic [3:0] i_cnt_issue,
   input wire logic [3:0] i_cnt_repeat,
   input wire logic [3:0] i_cnt_latency,
   output logic o_ready
);
   //////////////////////////////////////////////////////////////////////////
   logic [4:0] flags_reg; // current status flags
   logic [4:0] flags_next;
   logic [3:0] wait_reg; // cycles still to hold the next issue
   logic [3:0] wait_next;

   // extension by size; size codes from the package, byte/half widths written out as literals
   function automatic logic [31:0] cfe_extend(input logic [31:0] v, input logic [1:0] sz,
                                              input logic sgn);
      logic [31:0] r;
      r = v;
      case (sz)
         cfe_pkg::CFE_SZ_BYTE: r = sgn ? {{24{v[7]}}, v[7:0]} : {24'h000000, v[7:0]};
         cfe_pkg::CFE_SZ_HALF: r = sgn ? {{16{v[15]}}, v[15:0]} : {16'h0000, v[15:0]};
         default: r = v;
      endcase
      return r;
   endfunction : cfe_extend

   //////////////////////////////////////////////////////////////////////////
   // condition evaluator, combinational straight through
   cfe_cond_eval u_cond (
      .i_cond(i_cond),
      .i_flags(flags_reg),
      .o_true(o_cond_true)
   );

   // spot checks of the evaluator against the registered flags that it sees
   property p_cond_ge;
      @(posedge i_ref_clk) disable iff (!i_resetn)
         (i_cond == cfe_pkg::CC_GE) |->
            (o_cond_true == (flags_reg[cfe_pkg::FLG_S] == flags_reg[cfe_pkg::FLG_OV]));
   endproperty
   a_cond_ge: assert property (p_cond_ge) else $error("ge test wrong");
   property p_cond_gt;
      @(posedge i_ref_clk) disable iff (!i_resetn)
         (i_cond == cfe_pkg::CC_GT) |-> (o_cond_true == !((flags_reg[cfe_pkg::FLG_S]
            ^ flags_reg[cfe_pkg::FLG_OV]) | flags_reg[cfe_pkg::FLG_Z]));
   endproperty
   a_cond_gt: assert property (p_cond_gt) else $error("gt test wrong");
   property p_cond_h;
      @(posedge i_ref_clk) disable iff (!i_resetn)
         (i_cond == cfe_pkg::CC_H) |->
            (o_cond_true == !(flags_reg[cfe_pkg::FLG_CY] | flags_reg[cfe_pkg::FLG_Z]));
   endproperty
   a_cond_h: assert property (p_cond_h) else $error("higher test wrong");
   property p_cond_always;
      @(posedge i_ref_clk) disable iff (!i_resetn)
         (i_cond == cfe_pkg::CC_T) |-> o_cond_true;
   endproperty
   a_cond_always: assert property (p_cond_always) else $error("always not true");
   property p_cond_ov;
      @(posedge i_ref_clk) disable iff (!i_resetn)
         (i_cond == cfe_pkg::CC_NOV) |-> (o_cond_true != flags_reg[cfe_pkg::FLG_OV]);
   endproperty
   a_cond_ov: assert property (p_cond_ov) else $error("no-overflow test wrong");

   // per-flag action selection, one slice per flag
   genvar g;
   generate
      for (g = 0; g < cfe_pkg::NFLG; g++) begin : g_flag
         always_comb begin
            case (cfe_pkg::cfe_upd_t'(i_upd_codes[2*g +: 2]))
               cfe_pkg::CFE_UPD_CLR: flags_next[g] = 1'b0;
               cfe_pkg::CFE_UPD_RES: flags_next[g] = i_result_flags[g];
               cfe_pkg::CFE_UPD_RST: flags_next[g] = i_saved_flags[g];
               default: flags_next[g] = flags_reg[g];
            endcase
         end
      end
   endgenerate

   // flags only move on a valid update
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         flags_reg <= cfe_pkg::FLAGS_RST;
      end else if (i_upd_valid) begin
         flags_reg <= flags_next;
      end
   end
   assign o_flags = flags_reg;

   // one flag per action code: clear, keep and restore each seen one edge later
   property p_flag_clr;
      @(posedge i_ref_clk) disable iff (!i_resetn)
         (i_upd_valid && i_upd_codes[3:2] == 2'h1) |=> !o_flags[1];
   endproperty
   a_flag_clr: assert property (p_flag_clr) else $error("overflow not cleared");
   property p_flag_keep;
      @(posedge i_ref_clk) disable iff (!i_resetn)
         (!i_upd_valid || i_upd_codes[1:0] == 2'h0) |=> $stable(o_flags[0]);
   endproperty
   a_flag_keep: assert property (p_flag_keep) else $error("carry changed on keep");
   property p_flag_rst;
      @(posedge i_ref_clk) disable iff (!i_resetn)
         (i_upd_valid && i_upd_codes[9:8] == 2'h3) |=> (o_flags[4] == $past(i_saved_flags[4]));
   endproperty
   a_flag_rst: assert property (p_flag_rst) else $error("sat not restored");

   //////////////////////////////////////////////////////////////////////////
   // datapath helpers, combinational
   assign o_ext_out = cfe_extend(i_ext_in, i_ext_size, i_ext_signed);

   // 33-bit signed input lets out-of-range sums be seen before clamping
   always_comb begin
      if (!i_sat_in[32] && (i_sat_in[31:0] >= cfe_pkg::SAT_MAX)) begin
         o_sat_out = cfe_pkg::SAT_MAX;
         o_sat_hit = (i_sat_in[31:0] != cfe_pkg::SAT_MAX);
      end else if (i_sat_in[32] && (i_sat_in[31:0] <= cfe_pkg::SAT_MIN)) begin
         o_sat_out = cfe_pkg::SAT_MIN;
         o_sat_hit = (i_sat_in[31:0] != cfe_pkg::SAT_MIN);
      end else begin
         o_sat_out = i_sat_in[31:0];
         o_sat_hit = 1'b0;
      end
   end

   // anything below the negative limit must come out as the limit itself
   property p_sat;
      @(posedge i_ref_clk) disable iff (!i_resetn)
         (i_sat_in[32] && !i_sat_in[31]) |-> (o_sat_out == cfe_pkg::SAT_MIN);
   endproperty
   a_sat: assert property (p_sat) else $error("negative overflow not clamped");

   assign o_bit_rd = i_mem_byte[i_bit_num];
   always_comb begin
      o_bit_wr_byte = i_mem_byte;
      o_bit_wr_byte[i_bit_num] = i_bit_val;
   end

   // the write may touch the selected bit only
   property p_bitwr;
      @(posedge i_ref_clk) disable iff (!i_resetn)
         (((o_bit_wr_byte ^ i_mem_byte) & ~(8'h01 << i_bit_num)) == 8'h00)
            && (o_bit_wr_byte[i_bit_num] == i_bit_val);
   endproperty
   a_bitwr: assert property (p_bitwr) else $error("bit write disturbed byte");

   //////////////////////////////////////////////////////////////////////////
   // issue spacing: the longest of the counts that apply to the follower
   always_comb begin
      wait_next = wait_reg;
      if (i_issue && o_ready) begin
         wait_next = i_cnt_issue;
         if (i_same_insn && i_cnt_repeat > wait_next) wait_next = i_cnt_repeat;
         if (i_dependent && i_cnt_latency > wait_next) wait_next = i_cnt_latency;
         wait_next = (wait_next == 4'h0) ? 4'h0 : wait_next - 4'h1;
      end else if (wait_reg != 4'h0) begin
         wait_next = wait_reg - 4'h1;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         wait_reg <= 4'h0;
      end else begin
         wait_reg <= wait_next;
      end
   end
   assign o_ready = (wait_reg == 4'h0);

   // a plain issue count of three holds the follower off for two cycles
   property p_issue;
      @(posedge i_ref_clk) disable iff (!i_resetn)
         (i_issue && o_ready && !i_same_insn && !i_dependent && i_cnt_issue == 4'h3)
            |=> !o_ready ##1 !o_ready ##1 o_ready;
   endproperty
   a_issue: assert property (p_issue) else $error("issue spacing wrong");

endmodule : cfe_top
`default_nettype wire

// File: pkg/cfe_pkg.sv
`default_nettype none
package cfe_pkg;
   // word geometry
   localparam int WORD_W = 32;
   localparam int BYTE_W = 8;
   localparam int HALF_W = 16;
   // saturation bounds
   localparam logic [31:0] SAT_MAX = 32'h7FFFFFFF;
   localparam logic [31:0] SAT_MIN = 32'h80000000;
   // flag vector bit positions: {sat, sign, zero, overflow, carry}
   localparam int FLG_CY = 0;
   localparam int FLG_OV = 1;
   localparam int FLG_Z = 2;
   localparam int FLG_S = 3;
   localparam int FLG_SAT = 4;
   localparam int NFLG = 5;
   localparam logic [4:0] FLAGS_RST = 5'h00;
   // per-flag update action codes
   typedef enum logic [1:0] {
      CFE_UPD_KEEP = 2'h0,
      CFE_UPD_CLR = 2'h1,
      CFE_UPD_RES = 2'h2,
      CFE_UPD_RST = 2'h3
   } cfe_upd_t;
   // extension size selection
   typedef enum logic [1:0] {
      CFE_SZ_BYTE = 2'h0,
      CFE_SZ_HALF = 2'h1,
      CFE_SZ_WORD = 2'h2
   } cfe_size_t;
   // condition codes
   localparam logic [3:0] CC_OV = 4'h0;
   localparam logic [3:0] CC_NOV = 4'h8;
   localparam logic [3:0] CC_CY = 4'h1;
   localparam logic [3:0] CC_NCY = 4'h9;
   localparam logic [3:0] CC_Z = 4'h2;
   localparam logic [3:0] CC_NZ = 4'hA;
   localparam logic [3:0] CC_NH = 4'h3;
   localparam logic [3:0] CC_H = 4'hB;
   localparam logic [3:0] CC_N = 4'h4;
   localparam logic [3:0] CC_P = 4'hC;
   localparam logic [3:0] CC_T = 4'h5;
   localparam logic [3:0] CC_SA = 4'hD;
   localparam logic [3:0] CC_LT = 4'h6;
   localparam logic [3:0] CC_GE = 4'hE;
   localparam logic [3:0] CC_LE = 4'h7;
   localparam logic [3:0] CC_GT = 4'hF;
endpackage : cfe_pkg
`default_nettype wire

// File: logic/cfe_cond_eval.sv
`timescale 1ns/10ps
`default_nettype none
// purely combinational condition test, shared wherever a cccc field is met
module cfe_cond_eval (
   input wire logic [3:0] i_cond,
   input wire logic [4:0] i_flags,
   output logic o_true
);
   logic cy, ov, z, s, saturation_flag; // unpacked flags
   assign cy = i_flags[cfe_pkg::FLG_CY];
   assign ov = i_flags[cfe_pkg::FLG_OV];
   assign z = i_flags[cfe_pkg::FLG_Z];
   assign s = i_flags[cfe_pkg::FLG_S];
   assign saturation_flag = i_flags[cfe_pkg::FLG_SAT];

   // one test per code, no state
   always_comb begin
      case (i_cond)
         cfe_pkg::CC_OV: o_true = ov;
         cfe_pkg::CC_NOV: o_true = !ov;
         cfe_pkg::CC_CY: o_true = cy;
         cfe_pkg::CC_NCY: o_true = !cy;
         cfe_pkg::CC_Z: o_true = z;
         cfe_pkg::CC_NZ: o_true = !z;
         cfe_pkg::CC_NH: o_true = cy | z;
         cfe_pkg::CC_H: o_true = !(cy | z);
         cfe_pkg::CC_N: o_true = s;
         cfe_pkg::CC_P: o_true = !s;
         cfe_pkg::CC_T: o_true = 1'b1;
         cfe_pkg::CC_SA: o_true = saturation_flag;
         cfe_pkg::CC_LT: o_true = s ^ ov;
         cfe_pkg::CC_GE: o_true = !(s ^ ov);
         cfe_pkg::CC_LE: o_true = (s ^ ov) | z;
         cfe_pkg::CC_GT: o_true = !((s ^ ov) | z);
         default: o_true = 1'b0;
      endcase
   end
endmodule : cfe_cond_eval
`default_nettype wire

// File: tb/cfe_core_model.sv
`timescale 1ns/10ps
`default_nettype none
// core side: keeps the saved status copy that a restore code reloads
module cfe_core_model (
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic i_save,
   input wire logic [4:0] i_flags,
   output logic [4:0] o_saved_flags
);
   // backup register, written only on an exception-style save
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         o_saved_flags <= 5'h00;
      end else if (i_save) begin
         o_saved_flags <= i_flags;
      end
   end
endmodule : cfe_core_model
`default_nettype wire

// File: tb/tb_cfe_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_cfe_top;
   logic clk = 1'b0, rstn = 1'b0, upd = 1'b0, sv = 1'b0, esg = 1'b0, bv = 1'b0;
   logic iss = 1'b0, same = 1'b0, dep = 1'b0, ct, sh, brd;
   logic [3:0] cond = 4'h0, ci = 4'h0, cr = 4'h0, cl = 4'h0;
   logic [9:0] codes = 10'h000;
   logic [4:0] res = 5'h00, saved, flg;
   logic [31:0] ein = 32'h00000000, eout, sout;
   logic [1:0] esz = 2'h0;
   logic [32:0] sin = 33'h000000000;
   logic [7:0] mb = 8'h00, bwr;
   logic [2:0] bn = 3'h0;
   logic rdy;
   int n_fail = 0, comparisons = 0;
   cfe_top i_dut (.i_ref_clk(clk), .i_resetn(rstn), .i_cond(cond), .o_cond_true(ct),
      .i_upd_valid(upd), .i_upd_codes(codes), .i_result_flags(res), .i_saved_flags(saved),
      .o_flags(flg), .i_ext_in(ein), .i_ext_size(esz), .i_ext_signed(esg), .o_ext_out(eout),
      .i_sat_in(sin), .o_sat_out(sout), .o_sat_hit(sh), .i_mem_byte(mb), .i_bit_num(bn),
      .i_bit_val(bv), .o_bit_rd(brd), .o_bit_wr_byte(bwr), .i_issue(iss), .i_same_insn(same),
      .i_dependent(dep), .i_cnt_issue(ci), .i_cnt_repeat(cr), .i_cnt_latency(cl), .o_ready(rdy));
   cfe_core_model i_core (.i_ref_clk(clk), .i_resetn(rstn), .i_save(sv), .i_flags(flg),
      .o_saved_flags(saved));
   //////////////////////////////////////////////////////////////////////////
   initial begin
      forever #5 clk = ~clk;
   end
   // word results: extension and saturation outputs
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // single-bit results: condition, clamp hit, bit read, ready
   task automatic chk_bit(input string nm, input logic e, input logic g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %b seen %b", nm, e, g);
      end
   endtask : chk_bit
   // status flag vector
   task automatic chk_flags(input string nm, input logic [4:0] e, input logic [4:0] g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_flags
   // byte handed back by the bit write helper
   task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_byte
   task automatic tally_and_finish;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish
   task automatic step;
      @(posedge clk);
      #1;
   endtask : step
   // one flag update pulse; new flags visible one edge later, then an idle
   // edge so that two calls never lower and raise the strobe at one instant
   task automatic upd_flags(input logic [9:0] c, input logic [4:0] r);
      upd = 1'b1;
      codes = c;
      res = r;
      step();
      upd = 1'b0;
      step();
   endtask : upd_flags
   // reference condition table, bits {sat, sign, zero, overflow, carry}
   function automatic logic ref_cond(input logic [3:0] c, input logic [4:0] f);
      logic [7:0] b;
      b = {(f[3] ^ f[1]) | f[2], f[3] ^ f[1], 1'b1, f[3], f[0] | f[2], f[2], f[0], f[1]};
      if (c == 4'h5) return 1'b1;
      if (c == 4'hD) return f[4];
      return b[c[2:0]] ^ c[3];
   endfunction : ref_cond
   // every condition code against every flag combination, loaded via updates
   task automatic t_cond;
      for (int f = 0; f < 32; f++) begin
         upd_flags(10'h2AA, f[4:0]);
         chk_flags("flags", f[4:0], flg);
         for (int c = 0; c < 16; c++) begin
            cond = c[3:0];
            step();
            chk_bit("cond", ref_cond(c[3:0], f[4:0]), ct);
         end
      end
   endtask : t_cond
   // mixed keep / clear / result / restore codes in one update
   task automatic t_restore;
      upd_flags(10'h2AA, 5'h15);
      sv = 1'b1;
      step();
      sv = 1'b0;
      upd_flags(10'h2AA, 5'h0A);
      upd_flags(10'h3E4, 5'h04);
      chk_flags("flags mix", 5'h14, flg);
      step();
      chk_flags("flags hold", 5'h14, flg);
   endtask : t_restore
   // reset in mid-run: flags and a pending issue stall return to idle
   task automatic t_reset;
      ci = 4'h6;
      iss = 1'b1;
      step();
      iss = 1'b0;
      chk_bit("ready before reset", 1'b0, rdy);
      rstn = 1'b0;
      step();
      chk_flags("reset flags", 5'h00, flg);
      chk_bit("reset ready", 1'b1, rdy);
      rstn = 1'b1;
      step();
   endtask : t_reset
   // inputs change just after an edge and are judged one edge later
   task automatic ext1(input logic [1:0] z, input logic s, input logic [31:0] e);
      esz = z;
      esg = s;
      step();
      chk("ext", e, eout);
   endtask : ext1
   task automatic t_ext;
      ein = 32'h89ABCDEF;
      ext1(2'h0, 1'b0, 32'h000000EF);
      ext1(2'h0, 1'b1, 32'hFFFFFFEF);
      ext1(2'h1, 1'b0, 32'h0000CDEF);
      ext1(2'h1, 1'b1, 32'hFFFFCDEF);
      ext1(2'h2, 1'b1, 32'h89ABCDEF);
      ext1(2'h3, 1'b0, 32'h89ABCDEF);
      ein = 32'h8000807F;
      ext1(2'h0, 1'b1, 32'h0000007F);
   endtask : t_ext
   task automatic sat1(input logic [32:0] v, input logic [31:0] e, input logic h);
      sin = v;
      step();
      chk("sat", e, sout);
      chk_bit("sat hit", h, sh);
   endtask : sat1
   task automatic t_sat;
      sat1(33'h07FFFFFFF, 32'h7FFFFFFF, 1'b0);
      sat1(33'h080000000, 32'h7FFFFFFF, 1'b1);
      sat1(33'h180000000, 32'h80000000, 1'b0);
      sat1(33'h17FFFFFFF, 32'h80000000, 1'b1);
      sat1(33'h1FFFFFFFE, 32'hFFFFFFFE, 1'b0);
   endtask : t_sat
   // each bit number: read it, then write its inverse
   task automatic t_bit;
      mb = 8'hA5;
      for (int n = 0; n < 8; n++) begin
         bn = n[2:0];
         bv = ~mb[n];
         step();
         chk_bit("bit rd", mb[n], brd);
         chk_byte("bit wr", mb ^ (8'h01 << n), bwr);
      end
   endtask : t_bit
   // issue, then ready must stay low n-1 cycles; a request while low is ignored
   task automatic t_iss(input logic [3:0] a, b, c, input logic s, d, input int n);
      {ci, cr, cl, same, dep} = {a, b, c, s, d};
      iss = 1'b1;
      step();
      for (int k = 1; k < n; k++) begin
         iss = (k == 1 && n > 2);
         chk_bit("ready low", 1'b0, rdy);
         step();
      end
      iss = 1'b0;
      chk_bit("ready", 1'b1, rdy);
      // idle edge: the next call raises the issue strobe at a later instant
      step();
   endtask : t_iss
   //////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clk);
      #1 rstn = 1'b1;
      chk_flags("reset flags", 5'h00, flg);
      chk_bit("reset ready", 1'b1, rdy);
      t_cond();
      t_restore();
      t_reset();
      t_ext();
      t_sat();
      t_bit();
      t_iss(4'h3, 4'h0, 4'h0, 1'b0, 1'b0, 3);
      t_iss(4'h2, 4'h4, 4'h0, 1'b1, 1'b0, 4);
      t_iss(4'h2, 4'h0, 4'h5, 1'b0, 1'b1, 5);
      t_iss(4'h2, 4'h7, 4'h0, 1'b0, 1'b0, 2);
      t_iss(4'h1, 4'h0, 4'h0, 1'b0, 1'b0, 1);
      tally_and_finish();
   end
   // hang guard: the whole run needs well under this
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      tally_and_finish();
   end
endmodule : tb_cfe_top
`default_nettype wire
